// ===== common/bloe_pkg.sv
// Purpose: shared constants for the bit and logic instruction executor
// Assumes: 12-bit instruction words, 8-bit data, 32 file registers
// Notes: opcode fields sit in the top bits of the word
package bloe_pkg;
   localparam int INSTR_W = 12;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 5;
   localparam int BIT_W = 3;
   // field positions
   localparam int OP_HI = 11;
   localparam int OP6_LO = 6;
   localparam int OP4_LO = 8;
   localparam int DEST_POS = 5;
   localparam int BIT_LO = 5;
   // opcode values
   localparam logic [5:0] OP_AND_REG = 6'h05;
   localparam logic [3:0] OP_BIT_CLR = 4'h4;
   localparam logic [3:0] OP_BIT_SET = 4'h5;
   localparam logic [3:0] OP_BIT_TST_ZERO = 4'h6;
   // timer register address, reset values
   localparam logic [4:0] TIMER_ADDR = 5'h01;
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [7:0] DATA_ZERO = 8'h00;
   typedef enum logic [1:0] {BLOE_NONE, BLOE_AND, BLOE_CLR, BLOE_SET_OR_TEST} bloe_dummy_e;
endpackage

// ===== common/bloe_dec_if.sv
// Purpose: decoded fields between the decoder and the executor
// Assumes: one clock domain
// Notes: purely combinational carrier
`timescale 1ns/1ps
interface bloe_dec_if;
   logic is_and;
   logic is_clr;
   logic is_set;
   logic is_tst;
   logic dest_reg;
   logic [4:0] addr;
   logic [2:0] bit_idx;
   modport dec (output is_and, is_clr, is_set, is_tst, dest_reg, addr, bit_idx);
   modport exe (input is_and, is_clr, is_set, is_tst, dest_reg, addr, bit_idx);
endinterface

// ===== design/bloe_decode.sv
// Purpose: split an instruction word into operation and operand fields
// Assumes: word is stable while valid
// Notes: unknown opcodes decode to no operation
`timescale 1ns/1ps
module bloe_decode (
   input wire logic [11:0] instr_i,
   bloe_dec_if.dec dec
);
   always_comb begin
      dec.is_and = instr_i[bloe_pkg::OP_HI:bloe_pkg::OP6_LO] == bloe_pkg::OP_AND_REG;
      dec.is_clr = instr_i[bloe_pkg::OP_HI:bloe_pkg::OP4_LO] == bloe_pkg::OP_BIT_CLR;
      dec.is_set = instr_i[bloe_pkg::OP_HI:bloe_pkg::OP4_LO] == bloe_pkg::OP_BIT_SET;
      dec.is_tst = instr_i[bloe_pkg::OP_HI:bloe_pkg::OP4_LO] == bloe_pkg::OP_BIT_TST_ZERO;
      dec.dest_reg = instr_i[bloe_pkg::DEST_POS];
      dec.addr = instr_i[bloe_pkg::ADDR_W-1:0];
      dec.bit_idx = instr_i[bloe_pkg::BIT_LO+bloe_pkg::BIT_W-1:bloe_pkg::BIT_LO];
   end
endmodule

// ===== design/bloe_exec.sv
// Purpose: execute and-with-register, bit clear, bit set and bit test
// Assumes: register file read is combinational; port pins arrive asynchronous
// Notes: one instruction per cycle, results registered
`timescale 1ns/1ps
module bloe_exec #(
   parameter logic [4:0] PORT_A_ADDR = 5'h05,
   parameter logic [4:0] PORT_B_ADDR = 5'h06
) (
   input wire logic CLK_SYS_I,
   input wire logic RST_B_I,
   input wire logic INSTR_VALID_I,
   input wire logic [11:0] INSTR_I,
   input wire logic [7:0] REG_RDATA_I,
   input wire logic [7:0] PORT_A_PINS_I,
   input wire logic [7:0] PORT_B_PINS_I,
   input wire logic PRESCALER_ON_TIMER_I,
   output logic [4:0] REG_ADDR_O,
   output logic REG_WE_O,
   output logic [7:0] REG_WDATA_O,
   output logic [7:0] ACCUM_O,
   output logic ZERO_FLAG_O,
   output logic ZERO_WE_O,
   output logic SKIP_NEXT_O,
   output logic PRESCALER_CLR_O
);
   // the datapath is written for these widths; refuse any other package setting
   if ($bits(INSTR_I) != bloe_pkg::INSTR_W) begin : g_bad_instr_w
      $error("instruction width does not match the package");
   end

   if ($bits(REG_RDATA_I) != bloe_pkg::DATA_W) begin : g_bad_rdata_w
      $error("read data width does not match the package");
   end

   if ($bits(REG_WDATA_O) != bloe_pkg::DATA_W
         || $bits(ACCUM_O) != bloe_pkg::DATA_W) begin : g_bad_wdata_w
      $error("write data width does not match the package");
   end

   if ($bits(PORT_A_PINS_I) != bloe_pkg::DATA_W
         || $bits(PORT_B_PINS_I) != bloe_pkg::DATA_W) begin : g_bad_pins_w
      $error("pin group width does not match the package");
   end

   if ($bits(REG_ADDR_O) != bloe_pkg::ADDR_W) begin : g_bad_addr_w
      $error("register address width does not match the package");
   end

   if ((1 << bloe_pkg::BIT_W) != bloe_pkg::DATA_W) begin : g_bad_bit_w
      $error("bit index must cover exactly one data word");
   end

   // the address decode cannot tell clashing registers apart
   if (PORT_A_ADDR == PORT_B_ADDR) begin : g_port_clash
      $error("port addresses must differ");
   end

   if (PORT_A_ADDR == bloe_pkg::TIMER_ADDR) begin : g_port_a_on_timer
      $error("port a address must differ from the timer address");
   end

   if (PORT_B_ADDR == bloe_pkg::TIMER_ADDR) begin : g_port_b_on_timer
      $error("port b address must differ from the timer address");
   end

   typedef struct packed {
      logic [7:0] pa_m;
      logic [7:0] pa_s;
      logic [7:0] pb_m;
      logic [7:0] pb_s;
      logic [7:0] acc;
      logic [4:0] waddr;
      logic we;
      logic [7:0] wdata;
      logic zero;
      logic zero_we;
      logic skip;
      logic pre_clr;
   } bloe_state_s;

   bloe_state_s st_r;
   bloe_state_s st_nxt;
   bloe_dec_if dec_if ();

   bloe_decode u_decode (
      .instr_i(INSTR_I),
      .dec(dec_if.dec)
   );

   // operation kind, at most one per instruction word
   typedef enum logic [2:0] {
      BLOE_OP_NONE,
      BLOE_OP_AND,
      BLOE_OP_CLR,
      BLOE_OP_SET,
      BLOE_OP_TST
   } bloe_op_e;

   bloe_op_e op_kind;
   logic [7:0] src;
   logic [7:0] and_res;
   logic [7:0] mask;
   logic [7:0] clr_res;
   logic [7:0] set_res;
   logic and_zero;
   logic bit_is_zero;
   logic timer_hit;

   // opcodes are disjoint, so the order only fixes precedence
   always_comb begin
      op_kind = BLOE_OP_NONE;
      if (!INSTR_VALID_I) begin
         op_kind = BLOE_OP_NONE;
      end else if (dec_if.is_and) begin
         op_kind = BLOE_OP_AND;
      end else if (dec_if.is_clr) begin
         op_kind = BLOE_OP_CLR;
      end else if (dec_if.is_set) begin
         op_kind = BLOE_OP_SET;
      end else if (dec_if.is_tst) begin
         op_kind = BLOE_OP_TST;
      end else begin
         op_kind = BLOE_OP_NONE;
      end
   end

   // operand source for every operation
   always_comb begin
      // pins already passed two flops; latch value would hide external drive
      if (dec_if.addr == PORT_A_ADDR) begin
         src = st_r.pa_s;
      end else if (dec_if.addr == PORT_B_ADDR) begin
         src = st_r.pb_s;
      end else begin
         src = REG_RDATA_I;
      end
   end

   // all result candidates formed every cycle
   always_comb begin
      mask = 8'h01 << dec_if.bit_idx;
      and_res = st_r.acc & src;
      and_zero = and_res == bloe_pkg::DATA_ZERO;
      clr_res = src & ~mask;
      set_res = src | mask;
      bit_is_zero = (src & mask) == bloe_pkg::DATA_ZERO;
      timer_hit = dec_if.addr == bloe_pkg::TIMER_ADDR;
   end

   // next state: single writer of every register
   always_comb begin
      st_nxt = st_r;
      // two-flop synchronisers; only the second stage feeds logic
      st_nxt.pa_m = PORT_A_PINS_I;
      st_nxt.pa_s = st_r.pa_m;
      st_nxt.pb_m = PORT_B_PINS_I;
      st_nxt.pb_s = st_r.pb_m;

      // strobes are one-cycle pulses
      st_nxt.we = 1'b0;
      st_nxt.zero_we = 1'b0;
      st_nxt.skip = 1'b0;
      st_nxt.pre_clr = 1'b0;
      st_nxt.waddr = dec_if.addr;

      case (op_kind)
         BLOE_OP_AND: begin
            st_nxt.zero = and_zero;
            st_nxt.zero_we = 1'b1;
            if (dec_if.dest_reg) begin
               st_nxt.we = 1'b1;
               st_nxt.wdata = and_res;
            end else begin
               st_nxt.acc = and_res;
            end
         end
         BLOE_OP_CLR: begin
            st_nxt.we = 1'b1;
            st_nxt.wdata = clr_res;
         end
         BLOE_OP_SET: begin
            st_nxt.we = 1'b1;
            st_nxt.wdata = set_res;
         end
         BLOE_OP_TST: begin
            // skip only flagged; dropping the next word is the fetch path's job
            st_nxt.skip = bit_is_zero;
         end
         default: begin
            st_nxt.we = 1'b0;
         end
      endcase

      // only a real write to the timer touches the prescaler
      st_nxt.pre_clr = st_nxt.we && timer_hit && PRESCALER_ON_TIMER_I;
   end

   always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         st_r <= '0;
         st_r.acc <= bloe_pkg::ACC_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // every output straight from a register
   assign REG_ADDR_O = st_r.waddr;
   assign REG_WE_O = st_r.we;
   assign REG_WDATA_O = st_r.wdata;
   assign ACCUM_O = st_r.acc;
   assign ZERO_FLAG_O = st_r.zero;
   assign ZERO_WE_O = st_r.zero_we;
   assign SKIP_NEXT_O = st_r.skip;
   assign PRESCALER_CLR_O = st_r.pre_clr;
endmodule

// ===== sim/bloe_exec_properties.sv
// Purpose: port checks for bloe_exec
// Assumes: pins held steady around port reads
// Notes: pins held steady, so the synchroniser lag is not modelled
`timescale 1ns/1ps
module bloe_exec_properties (
   input wire logic CLK_SYS_I,
   input wire logic RST_B_I,
   input wire logic INSTR_VALID_I,
   input wire logic [11:0] INSTR_I,
   input wire logic [7:0] REG_RDATA_I,
   input wire logic [7:0] PORT_A_PINS_I,
   input wire logic [7:0] PORT_B_PINS_I,
   input wire logic PRESCALER_ON_TIMER_I,
   input wire logic [4:0] REG_ADDR_O,
   input wire logic REG_WE_O,
   input wire logic [7:0] REG_WDATA_O,
   input wire logic [7:0] ACCUM_O,
   input wire logic ZERO_FLAG_O,
   input wire logic ZERO_WE_O,
   input wire logic SKIP_NEXT_O,
   input wire logic PRESCALER_CLR_O
);
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (!RST_B_I);
   wire [3:0] op = INSTR_I[11:8];
   wire [4:0] fa = INSTR_I[4:0];
   wire [7:0] msk = 8'h01 << INSTR_I[7:5];
   wire [7:0] src = (fa == 5'h05) ? PORT_A_PINS_I : (fa == 5'h06) ? PORT_B_PINS_I : REG_RDATA_I;
   wire [7:0] and_res = ACCUM_O & src;
   wire [7:0] clr_res = src & ~msk;
   wire [7:0] set_res = src | msk;
   wire tbit = |(src & msk);
   wire bit_op = INSTR_VALID_I && (op == 4'h4 || op == 4'h5);
   wire and_op = INSTR_VALID_I && INSTR_I[11:6] == 6'h05;
   AST_AND_ACC: assert property (and_op && !INSTR_I[5] |=> !REG_WE_O && ZERO_WE_O &&
      ACCUM_O == $past(and_res) && ZERO_FLAG_O == (ACCUM_O == 8'h00)) else $error("and to acc");
   AST_AND_REG: assert property (and_op && INSTR_I[5] |=> REG_WE_O && $stable(ACCUM_O) &&
      REG_WDATA_O == $past(and_res) && ZERO_WE_O) else $error("and to reg");
   AST_BIT_ADDR: assert property (bit_op |=> REG_WE_O && REG_ADDR_O == $past(fa))
      else $error("bit address");
   AST_BIT_CLR: assert property (INSTR_VALID_I && op == 4'h4 |=>
      REG_WDATA_O == $past(clr_res) && !ZERO_WE_O) else $error("bit clear");
   AST_BIT_SET: assert property (INSTR_VALID_I && op == 4'h5 |=>
      REG_WDATA_O == $past(set_res) && !ZERO_WE_O) else $error("bit set");
   AST_TEST_SKIP: assert property (INSTR_VALID_I && op == 4'h6 |=>
      SKIP_NEXT_O == !$past(tbit)) else $error("skip");
   AST_TIMER_PRE: assert property ((bit_op || and_op && INSTR_I[5]) && fa == 5'h01 |=>
      PRESCALER_CLR_O == $past(PRESCALER_ON_TIMER_I)) else $error("prescaler");
endmodule

// ===== sim/bit_and_logic_op_exec_test.sv
// Purpose: directed test of bloe_exec
// Assumes: accumulator stays at reset value, no load path
// Notes: pins held fixed so the synchroniser lag never matters
`timescale 1ns/1ps
module bit_and_logic_op_exec_test;
   logic CLK_SYS_I = 1'b0, RST_B_I = 1'b0, INSTR_VALID_I = 1'b0, PRESCALER_ON_TIMER_I = 1'b0;
   logic [11:0] INSTR_I = 12'h000;
   logic [7:0] REG_RDATA_I = 8'h00, PORT_A_PINS_I = 8'h3c, PORT_B_PINS_I = 8'hc3;
   logic [4:0] REG_ADDR_O;
   logic [7:0] REG_WDATA_O, ACCUM_O;
   logic REG_WE_O, ZERO_FLAG_O, ZERO_WE_O, SKIP_NEXT_O, PRESCALER_CLR_O;
   int n_mismatch = 0, total_checks = 0;
   bloe_exec u_dut (
      .CLK_SYS_I(CLK_SYS_I),
      .RST_B_I(RST_B_I),
      .INSTR_VALID_I(INSTR_VALID_I),
      .INSTR_I(INSTR_I),
      .REG_RDATA_I(REG_RDATA_I),
      .PORT_A_PINS_I(PORT_A_PINS_I),
      .PORT_B_PINS_I(PORT_B_PINS_I),
      .PRESCALER_ON_TIMER_I(PRESCALER_ON_TIMER_I),
      .REG_ADDR_O(REG_ADDR_O),
      .REG_WE_O(REG_WE_O),
      .REG_WDATA_O(REG_WDATA_O),
      .ACCUM_O(ACCUM_O),
      .ZERO_FLAG_O(ZERO_FLAG_O),
      .ZERO_WE_O(ZERO_WE_O),
      .SKIP_NEXT_O(SKIP_NEXT_O),
      .PRESCALER_CLR_O(PRESCALER_CLR_O)
   );
   initial begin
      forever #2 CLK_SYS_I = ~CLK_SYS_I;
   end
   task chk(input logic [7:0] s, input logic [7:0] e);
      total_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("Error t=%0t seen %h exp %h", $time, s, e);
      end
   endtask
   task exe(input logic [11:0] w, input logic [7:0] rd);
      INSTR_I = w;
      REG_RDATA_I = rd;
      INSTR_VALID_I = 1'b1;
      @(posedge CLK_SYS_I);
      #1;
   endtask
   task t_and;
      exe(12'h15f, 8'h5a);
      chk({REG_WE_O, ZERO_WE_O, ZERO_FLAG_O}, 8'h03);
      exe(12'h17f, 8'h5a);
      chk({REG_WE_O, ZERO_FLAG_O, REG_ADDR_O}, 8'h7f);
      chk(REG_WDATA_O | ACCUM_O, 8'h00);
      $display("t_and done");
   endtask
   task t_bits;
      for (int b = 0; b < 8; b++) begin
         exe({4'h4, 3'(b), 5'h0a}, 8'ha5);
         chk(REG_WDATA_O, 8'ha5 & ~(8'h01 << b));
         chk({REG_WE_O, REG_ADDR_O}, 8'h2a);
         exe({4'h5, 3'(b), 5'h0a}, 8'ha5);
         chk(REG_WDATA_O, 8'ha5 | (8'h01 << b));
         exe({4'h6, 3'(b), 5'h0a}, 8'ha5);
         chk({7'h00, SKIP_NEXT_O}, ~(8'ha5 >> b) & 8'h01);
      end
      $display("t_bits done");
   endtask
   task t_side;
      exe(12'h505, 8'h00);
      chk(REG_WDATA_O, 8'h3d);
      PRESCALER_ON_TIMER_I = 1'b1;
      exe(12'h5e1, 8'h00);
      chk({PRESCALER_CLR_O, REG_WDATA_O[7:1]}, 8'hc0);
      exe(12'h141, 8'hff);
      chk({7'h00, PRESCALER_CLR_O}, 8'h00);
      PRESCALER_ON_TIMER_I = 1'b0;
      exe(12'h401, 8'hff);
      chk({7'h00, PRESCALER_CLR_O}, 8'h00);
      exe(12'h426, 8'h00);
      chk(REG_WDATA_O, 8'hc1);
      $display("t_side done");
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      #20000;
      n_mismatch++;
      end_sim;
   end
   initial begin
      repeat (6) @(posedge CLK_SYS_I);
      #1 RST_B_I = 1'b1;
      t_and;
      t_bits;
      t_side;
      INSTR_VALID_I = 1'b0;
      end_sim;
   end
endmodule
bind bloe_exec bloe_exec_properties u_props (
   .CLK_SYS_I(CLK_SYS_I),
   .RST_B_I(RST_B_I),
   .INSTR_VALID_I(INSTR_VALID_I),
   .INSTR_I(INSTR_I),
   .REG_RDATA_I(REG_RDATA_I),
   .PORT_A_PINS_I(PORT_A_PINS_I),
   .PORT_B_PINS_I(PORT_B_PINS_I),
   .PRESCALER_ON_TIMER_I(PRESCALER_ON_TIMER_I),
   .REG_ADDR_O(REG_ADDR_O),
   .REG_WE_O(REG_WE_O),
   .REG_WDATA_O(REG_WDATA_O),
   .ACCUM_O(ACCUM_O),
   .ZERO_FLAG_O(ZERO_FLAG_O),
   .ZERO_WE_O(ZERO_WE_O),
   .SKIP_NEXT_O(SKIP_NEXT_O),
   .PRESCALER_CLR_O(PRESCALER_CLR_O)
);
